//--- core/ramp_consts.svh
// named constants of the ramp shaper: ranges, reset values, register offsets
// assumes frequency counts of 0.01 Hz and time counts of 0.01 s
`ifndef RAMP_CONSTS_SVH
`define RAMP_CONSTS_SVH

`define FREQ_W          16
`define TIME_W          19
`define FREQ_MIN_CNT    32'h0000_0000
`define FREQ_MAX_CNT    16'h9C40
`define TIME_MIN_CNT    32'h0000_0001
`define TIME_MAX_CNT    32'h0005_7E40
`define SWELL_MIN       32'h0000_0001
`define SWELL_MAX       32'h0000_000A
`define CURV_MIN        32'h0000_0000
`define CURV_MAX        32'h0000_0032
`define SHAPE_MAX       32'h0000_0004
`define METHOD_MAX      32'h0000_0002
`define SET_MAX         32'h0000_0002
`define TERM_FUNC_PROFILE 6'h09

`define TIME_RST        19'h003E8
`define SWELL_RST       4'h2
`define CURV_RST        6'h0A
`define TERM_FUNC_RST   6'h3F

`define TICK_US         32'h0000_03E8
`define CLK_MHZ         32'h0000_0032
`define TIME_UNIT_US    32'h0000_2710

`define WEIGHT_ONE      10'sh040
`define BEND_MUL        11'sh003
`define BEND_SHIFT      3
`define TRI_MID         6'sh10
`define LIN_MID         6'sh0F
`define PCT_MUL         11'h019
`define PCT_SHIFT       4
`define PCT_FULL        7'h64
`define PROG_STEPS      32'h0000_0040
`define PROG_SHIFT      16
`define PROG_TOP        6'h3F

`define A_CTRL          8'h00
`define CTRL_RUN_BIT    2
`define SET_BASE        8'h10
`define MSET_BASE       8'h40
`define SET_STRIDE      8'h10
`define OFF_ACC1        8'h00
`define OFF_DEC1        8'h04
`define OFF_ACC2        8'h08
`define OFF_DEC2        8'h0C
`define OFF_METHOD      8'h00
`define OFF_ATF         8'h04
`define OFF_DTF         8'h08
`define A_ACC_SHAPE     8'h60
`define A_DEC_SHAPE     8'h64
`define A_ACC_SWELL     8'h68
`define A_DEC_SWELL     8'h6C
`define A_CURV_BASE     8'h70
`define A_TERM_BASE     8'h80
`define WORD_STRIDE     8'h04
`define A_FREQ_STAT     8'hA0
`define A_FLAG_STAT     8'hA4

`endif

//--- core/ramp_pkg.sv
// types of the ramp shaper: shape, method and ramp mode codes, module state
// assumes ramp_consts.svh on the include path
`include "ramp_consts.svh"

package ramp_pkg;

  typedef enum logic [2:0] {
    SHAPE_LINEAR,
    SHAPE_S,
    SHAPE_U,
    SHAPE_INV_U,
    SHAPE_EXT_S
  } shape_type;

  typedef enum logic [1:0] {
    METHOD_TERMINAL,
    METHOD_FREQ,
    METHOD_REVERSE
  } method_type;

  typedef enum logic [1:0] {
    MODE_HOLD,
    MODE_RISE,
    MODE_FALL
  } ramp_mode_type;

  typedef struct packed {
    logic [1:0]                    motor_set;
    logic                          run;
    logic [2:0][`TIME_W-1:0]       first_accel_time;
    logic [2:0][`TIME_W-1:0]       first_decel_time;
    logic [2:0][`TIME_W-1:0]       second_accel_time;
    logic [2:0][`TIME_W-1:0]       second_decel_time;
    logic [1:0][1:0]               profile_switch_method;
    logic [1:0][`FREQ_W-1:0]       accel_transition_freq;
    logic [1:0][`FREQ_W-1:0]       decel_transition_freq;
    logic [2:0]                    accel_shape_select;
    logic [2:0]                    decel_shape_select;
    logic [3:0]                    accel_swell_constant;
    logic [3:0]                    decel_swell_constant;
    logic [3:0][5:0]               ext_s_curvature;
    logic [7:0][5:0]               input_terminal_function;
    logic [7:0]                    term_meta;
    logic [7:0]                    term_sync;
    logic [`FREQ_W-1:0]            freq;
    logic                          out_rev;
    logic                          reversing;
    logic                          stage2;
    logic [31:0]                   acc;
    logic [31:0]                   tick_cnt;
    logic                          tick;
    logic [31:0]                   rdata;
  } state_type;

endpackage

//--- core/slope_shaper.sv
// slope weight of one ramp point for the selected curve
// assumes progress 0..63 scaled from output frequency against maximum, mirrored for deceleration
`timescale 1ns/100ps
`include "ramp_consts.svh"

module slope_shaper (
  input  wire logic                 [5:0] progress,
  input  wire ramp_pkg::shape_type        shape,
  input  wire logic                 [3:0] swell,
  input  wire logic                 [5:0] curv_start,
  input  wire logic                 [5:0] curv_end,
  output logic                      [7:0] weight
);
  import ramp_pkg::*;

  // deviation scaled by swell constant
  function automatic logic signed [9:0] bend(input logic [3:0] k, input logic signed [5:0] dev);
    logic signed [10:0] ks;
    logic signed [10:0] ds;
    logic signed [10:0] prod;
    ks   = 11'(k);
    ds   = 11'(dev);
    prod = ks * ds * `BEND_MUL; // R13
    return 10'(prod >>> `BEND_SHIFT);
  endfunction

  logic        [4:0] tri_v;
  logic signed [5:0] tri_dev;
  logic signed [5:0] lin_dev;
  logic        [6:0] pct;
  logic              edge_zone;
  logic signed [9:0] w;

  always_comb begin
    tri_v     = progress[5] ? 5'(`PROG_TOP - progress) : progress[4:0];
    tri_dev   = $signed({1'b0, tri_v}) - `TRI_MID;
    lin_dev   = `LIN_MID - $signed({1'b0, progress[5:1]});
    pct       = 7'((11'(progress) * `PCT_MUL) >> `PCT_SHIFT);
    edge_zone = (pct < 7'(curv_start)) || (pct >= 7'(`PCT_FULL - 7'(curv_end))); // R17
    unique case (shape) // R12
      SHAPE_LINEAR: w = `WEIGHT_ONE;
      SHAPE_S:      w = `WEIGHT_ONE + bend(swell, tri_dev);
      SHAPE_U:      w = `WEIGHT_ONE + bend(swell, lin_dev);
      SHAPE_INV_U:  w = `WEIGHT_ONE - bend(swell, lin_dev);
      SHAPE_EXT_S:  w = edge_zone ? `WEIGHT_ONE + bend(swell, tri_dev) : `WEIGHT_ONE; // R14
      default:      w = `WEIGHT_ONE;
    endcase
    weight = w[7:0];
  end

endmodule

//--- core/accel_decel_ramp_shaper.sv
// two-stage acceleration/deceleration ramp generator with curve shaping
// assumes a register port on clk, terminal pins asynchronous, command on clk
//
// Functional notes
// R01: stage choice is re-evaluated every cycle, so it swaps mid-ramp.
// R02: method 00 picks second stage purely from the profile-switch input level.
// R03: method 01 moves to second stage once output passes transition frequency.
// R04: method 02 uses second stage only while reversing rotation direction.
// R05: acceleration transition frequency clamped to 0..400.00 Hz, used by method 01.
// R06: deceleration transition frequency clamped to 0..400.00 Hz, used by method 01.
// R07: second acceleration time clamped to 0.01..3600 s, three motor sets.
// R08: second deceleration time clamped to 0.01..3600 s, three motor sets.
// R09: a terminal with function code 09 drives the profile-switch input.
// R10: switching method exists for sets one and two; times for all three.
// R11: acceleration and deceleration have independent shape selections.
// R12: shape codes: 00 linear, 01 S, 02 U, 03 inverted U, 04 extended S.
// R13: swell constant clamped to 1..10; larger swells the curve more.
// R14: two acceleration curvatures for extended S, each clamped to 0..50 percent.
// R15: two deceleration curvatures, 0..50 percent, separate from acceleration ones.
// R16: users avoid non-linear shapes with analog frequency sources.
// R17: all curvatures at 50 percent make extended S equal to S-curve.
// R18: profile-switch asserted selects second stage, deasserted selects first stage.
// R19: output moves toward command each control tick at selected slope.
`timescale 1ns/100ps
`include "ramp_consts.svh"

module accel_decel_ramp_shaper #(
  parameter logic [`FREQ_W-1:0] MAX_FREQ    = `FREQ_MAX_CNT,
  parameter int                 TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wr_data,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic      [31:0]        rd_data,
  input  wire logic [7:0]         terminal_in,
  input  wire logic [`FREQ_W-1:0] freq_command,
  input  wire logic               cmd_reverse,
  output logic      [`FREQ_W-1:0] out_freq,
  output logic                    out_reverse,
  output logic                    stage2_active
);
  import ramp_pkg::*;

  localparam logic [31:0] PSCALE   = 32'((`PROG_STEPS << `PROG_SHIFT) / 32'(MAX_FREQ));
  localparam logic [31:0] UNIT_DEN = 32'((`TIME_UNIT_US / `TICK_US) * 32'(`WEIGHT_ONE));

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [7:0] set_addr(input logic [7:0] base, input int n, input logic [7:0] off);
    return 8'(base + 8'(n) * `SET_STRIDE + off);
  endfunction

  function automatic logic [7:0] word_addr(input logic [7:0] base, input int n);
    return 8'(base + 8'(n) * `WORD_STRIDE);
  endfunction

  state_type          st_ff;
  state_type          nxt_st;
  logic               profile_switch_input;
  logic               mismatch;
  logic [`FREQ_W-1:0] cmd_lim;
  logic [`FREQ_W-1:0] target;
  ramp_mode_type      mode;
  logic [1:0]         method;
  logic               use_second;
  logic [`TIME_W-1:0] sel_time;
  logic [31:0]        den;
  logic [31:0]        credit;
  logic [31:0]        acc_sum;
  logic [31:0]        prog_full;
  logic [5:0]         prog;
  logic [5:0]         shape_prog;
  logic [2:0]         shape_code;
  logic [3:0]         shape_swell;
  logic [5:0]         curv_start;
  logic [5:0]         curv_end;
  logic [7:0]         weight;
  logic [31:0]        rv;

  slope_shaper shaper (
    .progress   (shape_prog),
    .shape      (shape_type'(shape_code)),
    .swell      (shape_swell),
    .curv_start (curv_start),
    .curv_end   (curv_end),
    .weight     (weight)
  );

  always_comb begin
    nxt_st               = st_ff;
    profile_switch_input = 1'b0;
    rv                   = 32'h0000_0000;

    // terminal pins, two flops before use
    nxt_st.term_meta = terminal_in;
    nxt_st.term_sync = st_ff.term_meta;
    for (int i = 0; i < 8; i++) begin
      if (st_ff.input_terminal_function[i] == `TERM_FUNC_PROFILE && st_ff.term_sync[i]) begin
        profile_switch_input = 1'b1; // R09
      end
    end

    // register writes
    if (wr_en) begin
      if (addr == `A_CTRL) begin
        nxt_st.motor_set = 2'(clamp({30'h0, wr_data[1:0]}, 32'h0, `SET_MAX));
        nxt_st.run       = wr_data[`CTRL_RUN_BIT];
      end
      for (int n = 0; n < 3; n++) begin
        if (addr == set_addr(`SET_BASE, n, `OFF_ACC1)) begin
          nxt_st.first_accel_time[n] = `TIME_W'(clamp(wr_data, `TIME_MIN_CNT, `TIME_MAX_CNT));
        end
        if (addr == set_addr(`SET_BASE, n, `OFF_DEC1)) begin
          nxt_st.first_decel_time[n] = `TIME_W'(clamp(wr_data, `TIME_MIN_CNT, `TIME_MAX_CNT));
        end
        if (addr == set_addr(`SET_BASE, n, `OFF_ACC2)) begin
          nxt_st.second_accel_time[n] = `TIME_W'(clamp(wr_data, `TIME_MIN_CNT, `TIME_MAX_CNT)); // R07
        end
        if (addr == set_addr(`SET_BASE, n, `OFF_DEC2)) begin
          nxt_st.second_decel_time[n] = `TIME_W'(clamp(wr_data, `TIME_MIN_CNT, `TIME_MAX_CNT)); // R08
        end
      end
      for (int n = 0; n < 2; n++) begin
        if (addr == set_addr(`MSET_BASE, n, `OFF_METHOD)) begin
          nxt_st.profile_switch_method[n] = (wr_data > `METHOD_MAX) ? 2'h0 : wr_data[1:0]; // R10
        end
        if (addr == set_addr(`MSET_BASE, n, `OFF_ATF)) begin
          nxt_st.accel_transition_freq[n] = `FREQ_W'(clamp(wr_data, `FREQ_MIN_CNT, 32'(MAX_FREQ))); // R05
        end
        if (addr == set_addr(`MSET_BASE, n, `OFF_DTF)) begin
          nxt_st.decel_transition_freq[n] = `FREQ_W'(clamp(wr_data, `FREQ_MIN_CNT, 32'(MAX_FREQ))); // R06
        end
      end
      if (addr == `A_ACC_SHAPE) begin
        nxt_st.accel_shape_select = (wr_data > `SHAPE_MAX) ? 3'h0 : wr_data[2:0]; // R11
      end
      if (addr == `A_DEC_SHAPE) begin
        nxt_st.decel_shape_select = (wr_data > `SHAPE_MAX) ? 3'h0 : wr_data[2:0]; // R11
      end
      if (addr == `A_ACC_SWELL) begin
        nxt_st.accel_swell_constant = 4'(clamp(wr_data, `SWELL_MIN, `SWELL_MAX)); // R13
      end
      if (addr == `A_DEC_SWELL) begin
        nxt_st.decel_swell_constant = 4'(clamp(wr_data, `SWELL_MIN, `SWELL_MAX)); // R13
      end
      for (int n = 0; n < 4; n++) begin
        if (addr == word_addr(`A_CURV_BASE, n)) begin
          nxt_st.ext_s_curvature[n] = 6'(clamp(wr_data, `CURV_MIN, `CURV_MAX)); // R14
        end
      end
      for (int n = 0; n < 8; n++) begin
        if (addr == word_addr(`A_TERM_BASE, n)) begin
          nxt_st.input_terminal_function[n] = wr_data[5:0];
        end
      end
    end

    // register reads, data valid in the next cycle only
    if (rd_en) begin
      if (addr == `A_CTRL) begin
        rv = {29'h0, st_ff.run, st_ff.motor_set};
      end
      for (int n = 0; n < 3; n++) begin
        if (addr == set_addr(`SET_BASE, n, `OFF_ACC1)) rv = 32'(st_ff.first_accel_time[n]);
        if (addr == set_addr(`SET_BASE, n, `OFF_DEC1)) rv = 32'(st_ff.first_decel_time[n]);
        if (addr == set_addr(`SET_BASE, n, `OFF_ACC2)) rv = 32'(st_ff.second_accel_time[n]);
        if (addr == set_addr(`SET_BASE, n, `OFF_DEC2)) rv = 32'(st_ff.second_decel_time[n]);
      end
      for (int n = 0; n < 2; n++) begin
        if (addr == set_addr(`MSET_BASE, n, `OFF_METHOD)) rv = 32'(st_ff.profile_switch_method[n]);
        if (addr == set_addr(`MSET_BASE, n, `OFF_ATF)) rv = 32'(st_ff.accel_transition_freq[n]);
        if (addr == set_addr(`MSET_BASE, n, `OFF_DTF)) rv = 32'(st_ff.decel_transition_freq[n]);
      end
      if (addr == `A_ACC_SHAPE) rv = 32'(st_ff.accel_shape_select);
      if (addr == `A_DEC_SHAPE) rv = 32'(st_ff.decel_shape_select);
      if (addr == `A_ACC_SWELL) rv = 32'(st_ff.accel_swell_constant);
      if (addr == `A_DEC_SWELL) rv = 32'(st_ff.decel_swell_constant);
      for (int n = 0; n < 4; n++) begin
        if (addr == word_addr(`A_CURV_BASE, n)) rv = 32'(st_ff.ext_s_curvature[n]);
      end
      for (int n = 0; n < 8; n++) begin
        if (addr == word_addr(`A_TERM_BASE, n)) rv = 32'(st_ff.input_terminal_function[n]);
      end
      if (addr == `A_FREQ_STAT) rv = 32'(st_ff.freq);
      if (addr == `A_FLAG_STAT) begin
        rv = {28'h0, st_ff.reversing, st_ff.stage2, st_ff.out_rev, profile_switch_input};
      end
    end
    nxt_st.rdata = rv;

    // control tick
    if (st_ff.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      nxt_st.tick_cnt = 32'h0000_0000;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
      nxt_st.tick     = 1'b0;
    end

    // target and direction
    mismatch = (cmd_reverse != st_ff.out_rev);
    cmd_lim  = (freq_command > MAX_FREQ) ? MAX_FREQ : freq_command;
    target   = (!st_ff.run || mismatch) ? `FREQ_W'(0) : cmd_lim;
    if (st_ff.freq < target) begin
      mode = MODE_RISE;
    end else if (st_ff.freq > target) begin
      mode = MODE_FALL;
    end else begin
      mode = MODE_HOLD;
    end
    if (mismatch && st_ff.freq == `FREQ_W'(0)) begin
      nxt_st.out_rev = cmd_reverse;
    end
    if (mismatch && st_ff.freq != `FREQ_W'(0)) begin
      nxt_st.reversing = 1'b1;
    end else if (!mismatch && mode == MODE_HOLD) begin
      nxt_st.reversing = 1'b0;
    end

    // stage selection, live every cycle
    method = (st_ff.motor_set < 2'h2) ? st_ff.profile_switch_method[st_ff.motor_set[0]] : 2'h0; // R10
    use_second = 1'b0;
    if (method == METHOD_FREQ) begin
      if (mode == MODE_RISE) begin
        use_second = st_ff.freq >= st_ff.accel_transition_freq[st_ff.motor_set[0]]; // R03
      end else if (mode == MODE_FALL) begin
        use_second = st_ff.freq >= st_ff.decel_transition_freq[st_ff.motor_set[0]]; // R03
      end
    end else if (method == METHOD_REVERSE) begin
      use_second = st_ff.reversing; // R04
    end else begin
      use_second = profile_switch_input; // R02 R18
    end
    nxt_st.stage2 = use_second;
    if (mode == MODE_FALL) begin
      sel_time = use_second ? st_ff.second_decel_time[st_ff.motor_set] : st_ff.first_decel_time[st_ff.motor_set]; // R01
    end else begin
      sel_time = use_second ? st_ff.second_accel_time[st_ff.motor_set] : st_ff.first_accel_time[st_ff.motor_set]; // R01
    end
    den = 32'(sel_time) * UNIT_DEN;

    // shape inputs
    prog_full   = (32'(st_ff.freq) * PSCALE) >> `PROG_SHIFT;
    prog        = (prog_full > 32'(`PROG_TOP)) ? `PROG_TOP : prog_full[5:0];
    shape_prog  = (mode == MODE_FALL) ? 6'(`PROG_TOP - prog) : prog;
    shape_code  = (mode == MODE_FALL) ? st_ff.decel_shape_select : st_ff.accel_shape_select; // R11
    shape_swell = (mode == MODE_FALL) ? st_ff.decel_swell_constant : st_ff.accel_swell_constant;
    curv_start  = (mode == MODE_FALL) ? st_ff.ext_s_curvature[2] : st_ff.ext_s_curvature[0]; // R15
    curv_end    = (mode == MODE_FALL) ? st_ff.ext_s_curvature[3] : st_ff.ext_s_curvature[1]; // R15
    credit      = 32'(MAX_FREQ) * 32'(weight);

    // credit per tick, one count per cycle while credit covers the cost
    acc_sum = st_ff.acc + (st_ff.tick ? credit : 32'h0000_0000); // R19
    if (mode == MODE_HOLD) begin
      nxt_st.acc = 32'h0000_0000;
    end else if (acc_sum >= den) begin
      nxt_st.acc  = acc_sum - den;
      nxt_st.freq = (mode == MODE_RISE) ? st_ff.freq + `FREQ_W'(1) : st_ff.freq - `FREQ_W'(1); // R19
    end else begin
      nxt_st.acc = acc_sum;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff                         <= '0;
      st_ff.first_accel_time        <= {3{`TIME_RST}};
      st_ff.first_decel_time        <= {3{`TIME_RST}};
      st_ff.second_accel_time       <= {3{`TIME_RST}};
      st_ff.second_decel_time       <= {3{`TIME_RST}};
      st_ff.accel_swell_constant    <= `SWELL_RST;
      st_ff.decel_swell_constant    <= `SWELL_RST;
      st_ff.ext_s_curvature         <= {4{`CURV_RST}};
      st_ff.input_terminal_function <= {8{`TERM_FUNC_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data       = st_ff.rdata;
  assign out_freq      = st_ff.freq;
  assign out_reverse   = st_ff.out_rev;
  assign stage2_active = st_ff.stage2;

endmodule

//--- tb/ramp_shaper_asserts.sv
// port-level checks of the ramp shaper
// assumes a bind to accel_decel_ramp_shaper, one clock, synchronous reset
`timescale 1ns/100ps
`include "ramp_consts.svh"

module ramp_shaper_asserts #(
  parameter logic [`FREQ_W-1:0] MAX_FREQ    = `FREQ_MAX_CNT,
  parameter int                 TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic [7:0]         addr,
  input wire logic [31:0]        wr_data,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire logic [31:0]        rd_data,
  input wire logic [7:0]         terminal_in,
  input wire logic [`FREQ_W-1:0] freq_command,
  input wire logic               cmd_reverse,
  input wire logic [`FREQ_W-1:0] out_freq,
  input wire logic               out_reverse,
  input wire logic               stage2_active
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_rd_idle;
    !rd_en |=> rd_data == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rd idle");
  property p_unmapped;
    rd_en && addr == 8'hFC |=> rd_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_ro_freq;
    rd_en && addr == 8'hA0 |=> rd_data == {16'h0, $past(out_freq)};
  endproperty
  a_ro_freq: assert property (p_ro_freq) else $error("freq status");
  property p_flag_read;
    rd_en && addr == 8'hA4 |=> rd_data[31:4] == 28'h0 && rd_data[1] == $past(out_reverse);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag status");
  property p_shape_wr_rd;
    wr_en && addr == 8'h64 && wr_data <= 32'h4 ##1 rd_en && addr == 8'h64 |=> rd_data == $past(wr_data, 2);
  endproperty
  a_shape_wr_rd: assert property (p_shape_wr_rd) else $error("shape readback");
  property p_step_one;
    out_freq != $past(out_freq) |-> out_freq == $past(out_freq) + 16'h1 || $past(out_freq) == out_freq + 16'h1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("freq jump");
  property p_toward;
    out_freq > $past(out_freq) |-> $past(out_freq) < $past(freq_command);
  endproperty
  a_toward: assert property (p_toward) else $error("rise past command");
  property p_idle_zero;
    out_freq == 16'h0 && freq_command == 16'h0 |=> out_freq == 16'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("moved at zero");
  property p_rev_at_zero;
    $changed(out_reverse) |-> $past(out_freq) == 16'h0;
  endproperty
  a_rev_at_zero: assert property (p_rev_at_zero) else $error("flip not at zero");
endmodule

bind accel_decel_ramp_shaper ramp_shaper_asserts #(.MAX_FREQ(MAX_FREQ), .TICK_CYCLES(TICK_CYCLES)) chk (.*);

//--- tb/drive_stage_model.sv
// operator command source facing the ramp shaper
// assumes requests from the bench, same clock as the shaper
`timescale 1ns/100ps
`include "ramp_consts.svh"

module drive_stage_model (
  input  wire logic               clk,
  input  wire logic [`FREQ_W-1:0] req_freq,
  input  wire logic               req_rev,
  output logic      [`FREQ_W-1:0] freq_command = 16'h0,
  output logic                    cmd_reverse = 1'b0
);
  // digital command only, never an analog source
  always @(posedge clk) begin
    freq_command <= req_freq;
    cmd_reverse  <= req_rev;
  end
endmodule

//--- tb/accel_decel_ramp_shaper_bench.sv
// self-checking bench of the ramp shaper
// assumes core files and the drive stage model compiled first
`timescale 1ns/100ps
`include "ramp_consts.svh"

module accel_decel_ramp_shaper_bench;
  logic               clk = 1'b0;
  logic               reset_n = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wr_data = 32'h0;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic [31:0]        rd_data;
  logic [7:0]         terminal_in = 8'h00;
  logic [`FREQ_W-1:0] req_freq = 16'h0;
  logic               req_rev = 1'b0;
  logic [`FREQ_W-1:0] freq_command;
  logic               cmd_reverse;
  logic [`FREQ_W-1:0] out_freq;
  logic               out_reverse;
  logic               stage2_active;
  logic [`FREQ_W-1:0] prev_freq = 16'h0;
  logic [`FREQ_W-1:0] tf;
  logic               tr;
  logic               rd_pend = 1'b0;
  logic [31:0]        exp_q[$];
  logic [31:0]        seed = 32'h0000_8A00;
  int                 fail_count = 0;
  int                 tests_run = 0;
  int                 s1 = 0;
  int                 s2 = 0;
  int                 b1;
  int                 b2;
  int                 cyc = 0;
  int                 dur;
  int                 d_s;
  localparam logic [39:0] RV_T [14] = '{40'h10_000003E8, 40'h3C_000003E8, 40'h68_00000002,
    40'h6C_00000002, 40'h70_0000000A, 40'h7C_0000000A, 40'h80_0000003F, 40'h9C_0000003F,
    40'h60_00000000, 40'h40_00000000, 40'h48_00000000, 40'hA0_00000000, 40'hA4_00000000, 40'hFC_00000000};
  localparam logic [71:0] CL_T [14] = '{72'h18_00000000_00000001, 72'h1C_000FFFFF_00057E40,
    72'h38_00012345_00012345, 72'h44_0000FFFF_00009C40, 72'h58_00001234_00001234,
    72'h68_00000000_00000001, 72'h6C_0000000F_0000000A, 72'h74_0000003F_00000032,
    72'h78_00000032_00000032, 72'h60_00000005_00000000, 72'h64_00000004_00000004,
    72'h40_00000003_00000000, 72'h50_00000002_00000002, 72'h00_00000007_00000006};

  accel_decel_ramp_shaper #(.TICK_CYCLES(50)) uut (.*);
  drive_stage_model partner (.*);

  always #10 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
  endtask

  task automatic idle();
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic go(input logic [15:0] f, input logic rv);
    req_freq <= f;
    req_rev <= rv;
    tf = f;
    tr = rv;
    b1 = s1;
    b2 = s2;
  endtask

  task automatic settle();
    dur = 0;
    while ((out_freq !== tf || out_reverse !== tr) && dur < 3000) begin
      @(posedge clk);
      dur++;
    end
    check("settled", 32'h0, 32'(dur == 3000));
    repeat (4) @(posedge clk);
  endtask

  // read results and step bookkeeping
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_freq <= out_freq;
    rd_pend <= rd_en;
    if (rd_pend) check("read data", exp_q.pop_front(), rd_data);
    if (out_freq != prev_freq && stage2_active) s2 <= s2 + 1;
    if (out_freq != prev_freq && !stage2_active) s1 <= s1 + 1;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (RV_T[i]) rd(RV_T[i][39:32], RV_T[i][31:0]);
    foreach (CL_T[i]) begin
      wr(CL_T[i][71:64], CL_T[i][63:32]);
      rd(CL_T[i][71:64], CL_T[i][31:0]);
    end
    wr(8'hFC, rnd());
    rd(8'hFC, 32'h0);
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), 32'h1);
    wr(8'h00, 32'h4);
    for (int s = 0; s < 5; s++) begin
      wr(8'h60, 32'(s));
      wr(8'h64, 32'(4 - s));
      idle();
      go(16'h012C, 1'b0);
      settle();
      if (s == 1) d_s = dur;
      rd(8'hA0, 32'h12C);
      idle();
      go(16'h0, 1'b0);
      settle();
    end
    for (int i = 0; i < 4; i++) wr(8'h70 + 8'(4 * i), 32'h32);
    wr(8'h60, 32'h4);
    idle();
    go(16'h012C, 1'b0);
    settle();
    check("ext s time", 32'h1, 32'(dur < d_s + 50 && d_s < dur + 50));
    go(16'h0, 1'b0);
    settle();
    wr(8'h60, 32'h0);
    wr(8'h88, 32'h9);
    idle();
    go(16'h0190, 1'b0);
    repeat (100) @(posedge clk);
    terminal_in <= 8'(rnd()) | 8'h04;
    settle();
    check("stage one steps", 32'h1, 32'(s1 > b1));
    check("stage two steps", 32'h1, 32'(s2 > b2));
    go(16'h0, 1'b0);
    settle();
    check("stage one steps", 32'h0, 32'(s1 > b1));
    rd(8'hA4, 32'h5);
    idle();
    terminal_in <= 8'(rnd()) & 8'hFB;
    wr(8'h40, 32'h1);
    wr(8'h44, 32'hC8);
    wr(8'h48, 32'hC8);
    idle();
    for (int k = 0; k < 2; k++) begin
      go(k ? 16'h0 : 16'h0190, 1'b0);
      settle();
      check("stage one steps", 32'h1, 32'(s1 > b1));
      check("stage two steps", 32'h1, 32'(s2 > b2));
    end
    wr(8'h40, 32'h2);
    idle();
    go(16'h012C, 1'b0);
    settle();
    check("stage two steps", 32'h0, 32'(s2 > b2));
    go(16'h012C, 1'b1);
    settle();
    check("stage one steps", 32'h1, 32'(s1 - b1 < 3));
    check("stage two steps", 32'h1, 32'(s2 > b2));
    rd(8'hA4, 32'h2);
    idle();
    idle();
    report_and_stop();
  end
endmodule
